// ===== bench/bsp_backup_switch_pins_tb.sv
// Purpose: Directed bench for the backup switch and pad block
// Assumes: Clock enable held high, other interrupt sources idle
// Notes: Supply moved in millivolts through the comparator model
`timescale 1ns/100ps
`default_nettype none
module bsp_backup_switch_pins_tb;
    logic mclk = 1'b0, srst = 1'b1, regWrEn = 1'b0, regRdEn = 1'b0;
    logic clockSource = 1'b0, tick16Hz = 1'b0, stampPinIn = 1'b0;
    logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData;
    logic [15:0] vddMv = 16'h0CE4, vbatMv = 16'h0BB8;
    logic vLow, vHigh, vBat, stOut, stOe, aOut, aOe, bOut, bOe, cOut, cOe;
    logic pullEn, pullStr, stEv, onBat, thSel;
    int n_fail = 0, n_checks = 0, aCnt = 0, eCnt = 0, pCnt = 0;
    int aRef = 0, eRef = 0, pRef = 0;
    logic [7:0] addrs [6] = '{8'h26, 8'h27, 8'h29, 8'h2A, 8'h2B, 8'h30};
    bsp_supply_model model (.vddMv(vddMv), .vbatMv(vbatMv), .vddAboveVthLow(vLow),
        .vddAboveVthHigh(vHigh), .vddAboveBat(vBat));
    bsp_backup_switch_pins dut (.mclk(mclk), .srst(srst), .clkEn(1'b1), .regWrEn(regWrEn),
        .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
        .vddAboveVthLow(vLow), .vddAboveVthHigh(vHigh), .vddAboveBat(vBat),
        .clockSource(clockSource), .otherIrqA(1'b0), .otherIrqB(1'b0), .tick16Hz(tick16Hz),
        .stampPinIn(stampPinIn), .stampPinOut(stOut), .stampPinOe(stOe), .irqPinAOut(aOut),
        .irqPinAOe(aOe), .irqPinBOut(bOut), .irqPinBOe(bOe), .clockPinOut(cOut),
        .clockPinOe(cOe), .stampPullupEn(pullEn), .stampPullupStrong(pullStr),
        .stampEvent(stEv), .onBackup(onBat), .switchThresholdSel(thSel));
    initial begin
        forever #2 mclk = ~mclk;
    end
    // Free-running pulse counters; tests note a reference and compare the rise
    always @(posedge mclk) begin
        aCnt <= aCnt + int'(aOe);
        eCnt <= eCnt + int'(stEv);
        pCnt <= pCnt + int'(pullEn);
    end
    task automatic fail(input string msg);
        n_fail++;
        $display("Error at %0t: %s", $time, msg);
    endtask
    task automatic chk1(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) fail("pin level mismatch");
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) fail("read data mismatch");
    endtask
    task automatic chkN(input int got, input int exp);
        n_checks++;
        if (got != exp) fail("pulse count mismatch");
    endtask
    task automatic settle;
        repeat (3) @(posedge mclk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        regWrEn <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge mclk);
        regWrEn <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk);
        regRdEn <= 1'b1;
        regAddr <= a;
        @(posedge mclk);
        regRdEn <= 1'b0;
        #1;
        chk8(regRdData, exp);
    endtask
    // Supply step, then time for flag, state and pads to follow
    task automatic sup(input logic [15:0] v);
        @(posedge mclk);
        vddMv <= v;
        repeat (4) @(posedge mclk);
        #1;
    endtask
    task automatic pin(input logic v);
        @(posedge mclk);
        stampPinIn <= v;
        settle;
    endtask
    task automatic tick;
        @(posedge mclk);
        tick16Hz <= 1'b1;
        @(posedge mclk);
        tick16Hz <= 1'b0;
        settle;
    endtask
    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        #40000;
        fail("watchdog expired");
        wrap_up;
    end
    initial begin
        repeat (16) @(posedge mclk);
        srst <= 1'b0;
        foreach (addrs[i]) rd(addrs[i], 8'h00);
        wr(8'h27, 8'hA5);
        rd(8'h27, 8'hA5);
        wr(8'h26, 8'hFF);
        rd(8'h26, 8'h07);
        chk1(thSel, 1'b1);
        sup(16'h0B54);
        chk1(onBat, 1'b0);
        sup(16'h0A8C);
        chk1(onBat, 1'b1);
        wr(8'h26, 8'h06);
        chk1(thSel, 1'b0);
        sup(16'h07D0);
        chk1(onBat, 1'b0);
        // Pulse mode on pin A, flag left set across both switches
        wr(8'h27, 8'h02);
        wr(8'h29, 8'h01);
        wr(8'h2A, 8'h01);
        wr(8'h2B, 8'h00);
        settle;
        aRef = aCnt;
        sup(16'h04B0);
        chk1(bOe, 1'b0);
        chkN(aCnt - aRef, 1);
        sup(16'h07D0);
        chk1(bOe, 1'b1);
        chkN(aCnt - aRef, 2);
        rd(8'h2B, 8'h01);
        wr(8'h29, 8'h81);
        wr(8'h2A, 8'h81);
        settle;
        chk1(aOe, 1'b1);
        chk1(bOut, 1'b0);
        wr(8'h2B, 8'h00);
        settle;
        chk1(aOe, 1'b0);
        chk1(bOut, 1'b1);
        rd(8'h2B, 8'h00);
        wr(8'h29, 8'h00);
        settle;
        aRef = aCnt;
        sup(16'h04B0);
        sup(16'h07D0);
        chkN(aCnt - aRef, 0);
        chk1(bOut, 1'b0);
        // Indicator ignores the flag that the last switch set
        wr(8'h27, 8'h01);
        sup(16'h04B0);
        chk1(aOe, 1'b1);
        chk1(aOut, 1'b0);
        chk1(cOe, 1'b0);
        sup(16'h07D0);
        chk1(aOe, 1'b0);
        wr(8'h27, 8'h03);
        sup(16'h04B0);
        chk1(aOe, 1'b0);
        sup(16'h07D0);
        wr(8'h27, 8'h00);
        settle;
        chk1(aOe, 1'b1);
        @(posedge mclk);
        clockSource <= 1'b1;
        settle;
        chk1(aOe, 1'b0);
        chk1(cOut, 1'b1);
        wr(8'h27, 8'h80);
        @(posedge mclk);
        #1;
        chk1(cOut, 1'b0);
        for (int f = 0; f < 4; f++) begin
            wr(8'h27, 8'(f << 2));
            settle;
            chk1(stOe, f == 1 || f == 2);
            if (f == 2) chk1(stOut, 1'b1);
            if (f == 1) chk1(stOut, 1'b0);
        end
        eRef = eCnt;
        pin(1'b1);
        pin(1'b0);
        chkN(eCnt - eRef, 1);
        wr(8'h27, 8'h2C);
        settle;
        eRef = eCnt;
        pin(1'b1);
        pin(1'b0);
        chkN(eCnt - eRef, 1);
        wr(8'h27, 8'h18);
        settle;
        pRef = pCnt;
        tick;
        chkN(pCnt - pRef, 0);
        // Switch detector: pin change counts only once sampled
        wr(8'h27, 8'h5C);
        tick;
        chk1(pullStr, 1'b1);
        eRef = eCnt;
        pRef = pCnt;
        pin(1'b1);
        chkN(eCnt - eRef, 0);
        tick;
        chkN(eCnt - eRef, 1);
        chkN(pCnt - pRef, 1);
        wrap_up;
    end
endmodule
`default_nettype wire

// ===== bench/bsp_monitor.sv
// Purpose: Port checker for the backup switch and pad block
// Assumes: One clock, synchronous active-high reset
// Notes: Pad register shadowed from observed writes
`timescale 1ns/100ps
`default_nettype none
module bsp_monitor (
    input wire logic mclk,
    input wire logic srst,
    input wire logic clkEn,
    input wire logic regWrEn,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic tick16Hz,
    input wire logic irqPinAOe,
    input wire logic irqPinBOe,
    input wire logic clockPinOut,
    input wire logic stampPullupEn,
    input wire logic stampPullupStrong,
    input wire logic stampEvent,
    input wire logic onBackup,
    input wire logic switchThresholdSel
);
    logic [7:0] padQ;
    logic [7:0] padD;
    logic wrCtl;
    // Shadow pad register; pads lag it by one cycle
    always_comb begin
        padD = padQ;
        if (clkEn && regWrEn && regAddr == bsp_pkg::OFF_PAD_FUNC) begin
            padD = regWrData;
        end
    end
    always_ff @(posedge mclk) begin
        padQ <= srst ? 8'h00 : padD;
    end
    assign wrCtl = clkEn && regWrEn && regAddr == bsp_pkg::OFF_SWITCH_CTRL;
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    chk_thresh_write:
        assert property (wrCtl |=> switchThresholdSel == $past(regWrData[0]))
        else $error("threshold bit wrong after write");
    chk_pinb_backup:
        assert property ($past(onBackup) |-> !irqPinBOe) else $error("pin B driven on backup");
    chk_clk_disable:
        assert property ($past(padQ[7]) |-> !clockPinOut) else $error("clock pin not forced low");
    chk_irqa_battery:
        assert property ($past(padQ[1:0]) == bsp_pkg::IRQA_BATTERY |-> irqPinAOe == $past(onBackup))
        else $error("pin A does not show supply state");
    chk_irqa_hiz:
        assert property ($past(padQ[1:0]) == bsp_pkg::IRQA_HIZ |-> !irqPinAOe)
        else $error("pin A driven in high impedance mode");
    chk_pull_tick:
        assert property (stampPullupEn |-> $past(tick16Hz) && $past(padQ[4])
            && $past(padQ[3:2]) == bsp_pkg::STAMP_INPUT) else $error("stray pull-up pulse");
    chk_pull_strength:
        assert property (stampPullupStrong == $past(padQ[6])) else $error("pull-up strength off");
    chk_stamp_single:
        assert property (stampEvent |=> !stampEvent) else $error("stamp event too long");
endmodule
bind bsp_backup_switch_pins bsp_monitor u_mon (.mclk(mclk), .srst(srst), .clkEn(clkEn),
    .regWrEn(regWrEn), .regAddr(regAddr), .regWrData(regWrData), .tick16Hz(tick16Hz),
    .irqPinAOe(irqPinAOe), .irqPinBOe(irqPinBOe), .clockPinOut(clockPinOut),
    .stampPullupEn(stampPullupEn), .stampPullupStrong(stampPullupStrong),
    .stampEvent(stampEvent), .onBackup(onBackup), .switchThresholdSel(switchThresholdSel));
`default_nettype wire

// ===== bench/bsp_supply_model.sv
// Purpose: Supply comparators standing in for the analog side
// Assumes: Voltages given in millivolts
// Notes: No hysteresis, so tests keep clear margins
`timescale 1ns/100ps
`default_nettype none
module bsp_supply_model #(
    parameter logic [15:0] VTH_LOW_MV = 16'h05DC,
    parameter logic [15:0] VTH_HIGH_MV = 16'h0AF0
) (
    input wire logic [15:0] vddMv,
    input wire logic [15:0] vbatMv,
    output logic vddAboveVthLow,
    output logic vddAboveVthHigh,
    output logic vddAboveBat
);
    // Ideal comparators for both thresholds and the battery
    assign vddAboveVthLow = vddMv > VTH_LOW_MV;
    assign vddAboveVthHigh = vddMv > VTH_HIGH_MV;
    assign vddAboveBat = vddMv > vbatMv;
endmodule
`default_nettype wire

// ===== design/bsp_backup_switch_pins.sv
// Purpose: Battery switch-over control, its interrupt path and the pad mode register
// Assumes: Comparator levels and clock source arrive synchronous to mclk
// Notes: Register port is a plain offset/strobe port; serial bus lives outside
// Functional notes
// - Bit 0 picks switch threshold: 0 gives 1.5 V, 1 gives 2.8 V.
// - Mode 11 switches to backup below the lower of threshold and battery.
// - Separate backup interrupt enables for pin A and pin B registers.
// - Flag can drive either pin as a pulse or a level following it.
// - Flag stays set until host clears it by command.
// - Pulse on every switch either way, even with flag still set.
// - Battery indicator on pin A shows only present supply state.
// - Pin B inactive on backup supply, driven only on main supply.
// - Eight-bit pad mode register with clock, pull, polarity, type, function fields.
// - Clock pin disable forces logic 0, else outputs selected clock.
// - Bit 6 selects switch-detector pull-up: 0 is 80 kOhm, 1 is 40 kOhm.
// - Polarity bit 0 means rising edge active, 1 falling edge active.
// - Stamp pin: 00 off, 01 pin B push-pull, 10 clock push-pull, 11 input.
// - Input type bit only matters when stamp pin is in input mode.
// - Pin A function: 00 clock, 01 battery indication, 10 interrupt, 11 Hi-Z.
// - Battery indication: Hi-Z on main supply, logic 0 on backup.
// - Switch mode samples at 16 Hz with pull-up; CMOS input off on backup.
`timescale 1ns/100ps
`default_nettype none

module bsp_backup_switch_pins (
    input wire logic mclk,
    input wire logic srst,
    input wire logic clkEn,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    input wire logic vddAboveVthLow,
    input wire logic vddAboveVthHigh,
    input wire logic vddAboveBat,
    input wire logic clockSource,
    input wire logic otherIrqA,
    input wire logic otherIrqB,
    input wire logic tick16Hz,
    input wire logic stampPinIn,
    output logic stampPinOut,
    output logic stampPinOe,
    output logic irqPinAOut,
    output logic irqPinAOe,
    output logic irqPinBOut,
    output logic irqPinBOe,
    output logic clockPinOut,
    output logic clockPinOe,
    output logic stampPullupEn,
    output logic stampPullupStrong,
    output logic stampEvent,
    output logic onBackup,
    output logic switchThresholdSel
);

    // Whole block state, registered in one place
    bsp_pkg::bsp_state_s stateQ;
    bsp_pkg::bsp_state_s stateD;

    // Field views of the live registers
    logic [1:0] switchoverMode;
    logic [1:0] irqAPinFunction;
    logic [1:0] stampPinFunction;

    // Supply decision
    logic vthOk;
    logic stayMain;
    logic toBackup;
    logic switchEvt;

    // Backup interrupt requests, index 0 is pin A and 1 is pin B
    logic [1:0] pinIrqEn;
    logic [1:0] pinLevelMode;
    logic [1:0] pinAssert;
    logic irqAAssert;
    logic irqBAssert;

    // Stamp input path
    logic stampRaw;
    logic stampActive;

    // Write strobes, one per mapped offset
    logic wrSwitch;
    logic wrPad;
    logic wrIrqA;
    logic wrIrqB;
    logic wrFlags;

    // Field views of the live registers, so writes act on the next cycle
    assign switchoverMode = stateQ.switchCtrl[bsp_pkg::BIT_MODE_HI:bsp_pkg::BIT_MODE_LO];
    assign irqAPinFunction = stateQ.padFunc[bsp_pkg::BIT_IRQA_FN_LO +: 2];
    assign stampPinFunction = stateQ.padFunc[bsp_pkg::BIT_STAMP_FN_LO +: 2];

    // Register write strobes
    // The clock enable gates only the state register, so strobes need no copy of it
    assign wrSwitch = regWrEn && (regAddr == bsp_pkg::OFF_SWITCH_CTRL);
    assign wrPad = regWrEn && (regAddr == bsp_pkg::OFF_PAD_FUNC);
    assign wrIrqA = regWrEn && (regAddr == bsp_pkg::OFF_IRQ_A_EN);
    assign wrIrqB = regWrEn && (regAddr == bsp_pkg::OFF_IRQ_B_EN);
    assign wrFlags = regWrEn && (regAddr == bsp_pkg::OFF_FLAGS);

    // Threshold pick and switch-over decision; hysteresis is the comparators' job
    always_comb begin
        vthOk = stateQ.switchCtrl[bsp_pkg::BIT_THRESH_SEL] ? vddAboveVthHigh
                                                           : vddAboveVthLow;
        // Mode 11 holds main while either comparator still passes
        case (switchoverMode)
            bsp_pkg::MODE_VTH: stayMain = vthOk;
            bsp_pkg::MODE_BAT: stayMain = vddAboveBat;
            bsp_pkg::MODE_HIGHER: stayMain = vthOk && vddAboveBat;
            bsp_pkg::MODE_LOWER: stayMain = vthOk || vddAboveBat;
            default: stayMain = vthOk;
        endcase
    end

    // Flag is set on the way to backup; a pulse is due on either change
    assign toBackup = !stayMain && !stateQ.onBackup;
    assign switchEvt = stayMain == stateQ.onBackup;

    // Gather each pin's enable and mode bits so both pins share one request path
    assign pinIrqEn = {stateQ.irqBEn[bsp_pkg::BIT_BACKUP_IRQ_EN],
                       stateQ.irqAEn[bsp_pkg::BIT_BACKUP_IRQ_EN]};
    assign pinLevelMode = {stateQ.irqBEn[bsp_pkg::BIT_LEVEL_MODE],
                           stateQ.irqAEn[bsp_pkg::BIT_LEVEL_MODE]};

    // Per-pin request: level follows the flag, pulse marks each switch
    // A pulse still fires while the flag waits to be cleared
    for (genvar p = 0; p < 2; p++) begin : gen_pin_irq
        assign pinAssert[p] = pinIrqEn[p]
            && (pinLevelMode[p] ? stateQ.backupFlag : switchEvt);
    end
    assign irqAAssert = pinAssert[0];
    assign irqBAssert = pinAssert[1];

    // Stamp input source: sampled switch level or direct pin
    always_comb begin
        if (stateQ.padFunc[bsp_pkg::BIT_STAMP_TYPE]) begin
            stampRaw = stateQ.stampLevel;
        end else begin
            stampRaw = stampPinIn;
        end
        // Edge compare in the polarity's sense
        if (stateQ.padFunc[bsp_pkg::BIT_STAMP_POL]) begin
            stampActive = stateQ.stampPrev && !stampRaw;
        end else begin
            stampActive = !stateQ.stampPrev && stampRaw;
        end
    end

    // Next-state logic for every flop of the block
    always_comb begin
        stateD = stateQ;
        // One-cycle outputs drop unless set again below
        stateD.stampEvent = 1'b0;
        stateD.pullupEn = 1'b0;

        // Register writes, applied straight away
        if (wrSwitch) begin
            stateD.switchCtrl = {5'h00, regWrData[2:0]};
        end
        if (wrPad) begin
            stateD.padFunc = regWrData;
        end
        if (wrIrqA) begin
            stateD.irqAEn = regWrData;
        end
        if (wrIrqB) begin
            stateD.irqBEn = regWrData;
        end

        // Flag: clear by writing 0, a new switch to backup in the same cycle wins
        if (wrFlags && !regWrData[bsp_pkg::BIT_BACKUP_FLAG]) begin
            stateD.backupFlag = 1'b0;
        end
        if (toBackup) begin
            stateD.backupFlag = 1'b1;
        end

        // Supply state follows the decision on every enabled edge
        stateD.onBackup = !stayMain;

        // Interrupt requests, merged with the block's other sources
        stateD.irqAReq = irqAAssert || otherIrqA;
        stateD.irqBReq = irqBAssert || otherIrqB;

        // Stamp input handling; type bit only looked at in input mode
        stateD.pullupStrong = stateQ.padFunc[bsp_pkg::BIT_PULL_SEL];
        stateD.stampValid = 1'b0;
        if (stampPinFunction == bsp_pkg::STAMP_INPUT) begin
            if (stateQ.padFunc[bsp_pkg::BIT_STAMP_TYPE]) begin
                // Pull-up only during the sample keeps switch current low
                if (tick16Hz) begin
                    stateD.pullupEn = 1'b1;
                    stateD.stampLevel = stampPinIn;
                end
                // Valid only once a first sample has landed, so a pin
                // resting high gives no false edge on entering the mode
                stateD.stampValid = stateQ.stampValid || stateQ.pullupEn;
            end else begin
                stateD.stampValid = !stateQ.onBackup;
            end
        end
        if (stateD.stampValid) begin
            stateD.stampPrev = stampRaw;
            stateD.stampEvent = stateQ.stampValid && stampActive;
        end

        // Pin A: open drain, active low
        stateD.irqAPad.out = 1'b0;
        case (irqAPinFunction)
            bsp_pkg::IRQA_CLOCK: begin
                stateD.irqAPad.oe = !stateQ.onBackup && !clockSource;
            end
            bsp_pkg::IRQA_BATTERY: begin
                stateD.irqAPad.oe = stateQ.onBackup;
            end
            bsp_pkg::IRQA_IRQ: begin
                stateD.irqAPad.oe = stateQ.irqAReq;
            end
            bsp_pkg::IRQA_HIZ: begin
                stateD.irqAPad.oe = 1'b0;
            end
            default: begin
                stateD.irqAPad.oe = 1'b0;
            end
        endcase

        // Pin B: push-pull active low, only while on main supply
        stateD.irqBPad.out = !stateQ.irqBReq;
        stateD.irqBPad.oe = !stateQ.onBackup;

        // Clock pin: disable bit forces 0, Hi-Z on backup
        stateD.clkPad.out = stateQ.padFunc[bsp_pkg::BIT_CLK_DIS] ? 1'b0 : clockSource;
        stateD.clkPad.oe = !stateQ.onBackup;

        // Stamp pin output modes, Hi-Z on backup
        case (stampPinFunction)
            bsp_pkg::STAMP_IRQB: begin
                stateD.stampPad.out = !stateQ.irqBReq;
                stateD.stampPad.oe = !stateQ.onBackup;
            end
            bsp_pkg::STAMP_CLOCK: begin
                stateD.stampPad.out = clockSource;
                stateD.stampPad.oe = !stateQ.onBackup;
            end
            // Disabled and input modes leave the pin floating
            default: begin
                stateD.stampPad.out = 1'b0;
                stateD.stampPad.oe = 1'b0;
            end
        endcase

        // Read data, registered; unmapped offsets read zero
        // Without a read strobe the last read data keeps standing
        if (regRdEn) begin
            case (regAddr)
                bsp_pkg::OFF_SWITCH_CTRL: stateD.rdData = stateQ.switchCtrl;
                bsp_pkg::OFF_PAD_FUNC: stateD.rdData = stateQ.padFunc;
                bsp_pkg::OFF_IRQ_A_EN: stateD.rdData = stateQ.irqAEn;
                bsp_pkg::OFF_IRQ_B_EN: stateD.rdData = stateQ.irqBEn;
                bsp_pkg::OFF_FLAGS: stateD.rdData = {7'h00, stateQ.backupFlag};
                default: stateD.rdData = 8'h00;
            endcase
        end
    end

    // State register; clock enable freezes everything
    // Reset wins over a low clock enable so a frozen block can still be reset
    always_ff @(posedge mclk) begin
        if (srst) begin
            stateQ <= '0;
            stateQ.switchCtrl <= bsp_pkg::RST_SWITCH_CTRL;
            stateQ.padFunc <= bsp_pkg::RST_PAD_FUNC;
            stateQ.irqAEn <= bsp_pkg::RST_IRQ_EN;
            stateQ.irqBEn <= bsp_pkg::RST_IRQ_EN;
        end else if (clkEn) begin
            stateQ <= stateD;
        end
    end

    // Outputs straight from flops
    // Register read port
    assign regRdData = stateQ.rdData;

    // Pad value and enable pairs
    assign stampPinOut = stateQ.stampPad.out;
    assign stampPinOe = stateQ.stampPad.oe;
    assign irqPinAOut = stateQ.irqAPad.out;
    assign irqPinAOe = stateQ.irqAPad.oe;
    assign irqPinBOut = stateQ.irqBPad.out;
    assign irqPinBOe = stateQ.irqBPad.oe;
    assign clockPinOut = stateQ.clkPad.out;
    assign clockPinOe = stateQ.clkPad.oe;

    // Stamp input status
    assign stampPullupEn = stateQ.pullupEn;
    assign stampPullupStrong = stateQ.pullupStrong;
    assign stampEvent = stateQ.stampEvent;

    // Supply status
    assign onBackup = stateQ.onBackup;
    assign switchThresholdSel = stateQ.switchCtrl[bsp_pkg::BIT_THRESH_SEL];

endmodule

`default_nettype wire

// ===== design/bsp_pkg.sv
// Purpose: Shared constants and types for the backup switch and pad mode block
// Assumes: Registers addressed by 8-bit offsets, 8-bit data
// Notes: Bit layouts of the enable and flag registers are fixed here
package bsp_pkg;

    // Register offsets
    localparam logic [7:0] OFF_SWITCH_CTRL = 8'h26;
    localparam logic [7:0] OFF_PAD_FUNC = 8'h27;
    localparam logic [7:0] OFF_IRQ_A_EN = 8'h29;
    localparam logic [7:0] OFF_IRQ_B_EN = 8'h2A;
    localparam logic [7:0] OFF_FLAGS = 8'h2B;

    // Switch control fields
    localparam int BIT_THRESH_SEL = 0;
    localparam int BIT_MODE_LO = 1;
    localparam int BIT_MODE_HI = 2;

    // Pad function fields
    localparam int BIT_CLK_DIS = 7;
    localparam int BIT_PULL_SEL = 6;
    localparam int BIT_STAMP_POL = 5;
    localparam int BIT_STAMP_TYPE = 4;
    localparam int BIT_STAMP_FN_LO = 2;
    localparam int BIT_IRQA_FN_LO = 0;

    // Enable and flag fields
    localparam int BIT_BACKUP_IRQ_EN = 0;
    localparam int BIT_LEVEL_MODE = 7;
    localparam int BIT_BACKUP_FLAG = 0;

    // Reset values
    localparam logic [7:0] RST_SWITCH_CTRL = 8'h00;
    localparam logic [7:0] RST_PAD_FUNC = 8'h00;
    localparam logic [7:0] RST_IRQ_EN = 8'h00;

    // Switch-over modes
    localparam logic [1:0] MODE_VTH = 2'h0;
    localparam logic [1:0] MODE_BAT = 2'h1;
    localparam logic [1:0] MODE_HIGHER = 2'h2;
    localparam logic [1:0] MODE_LOWER = 2'h3;

    // Interrupt-A pin functions
    localparam logic [1:0] IRQA_CLOCK = 2'h0;
    localparam logic [1:0] IRQA_BATTERY = 2'h1;
    localparam logic [1:0] IRQA_IRQ = 2'h2;
    localparam logic [1:0] IRQA_HIZ = 2'h3;

    // Stamp pin functions
    localparam logic [1:0] STAMP_OFF = 2'h0;
    localparam logic [1:0] STAMP_IRQB = 2'h1;
    localparam logic [1:0] STAMP_CLOCK = 2'h2;
    localparam logic [1:0] STAMP_INPUT = 2'h3;

    // Pad drive bundle: value and enable
    typedef struct packed {
        logic out;
        logic oe;
    } bsp_pad_s;

    // Whole block state
    typedef struct packed {
        logic [7:0] switchCtrl;
        logic [7:0] padFunc;
        logic [7:0] irqAEn;
        logic [7:0] irqBEn;
        logic backupFlag;
        logic onBackup;
        logic stampLevel;
        logic stampPrev;
        logic stampValid;
        logic stampEvent;
        logic pullupEn;
        logic pullupStrong;
        logic irqAReq;
        logic irqBReq;
        bsp_pad_s irqAPad;
        bsp_pad_s irqBPad;
        bsp_pad_s clkPad;
        bsp_pad_s stampPad;
        logic [7:0] rdData;
    } bsp_state_s;

endpackage
